// ===== pkg/adc_cal_defines.vh
/*
  Constants for the converter correction datapath and calibration sequencer:
  register offsets, field positions, reset values and mode codes.
  Assumes it is included by bare name from the design files.
*/
//
// Summary of operation
// - Average chopped pairs, subtract offset, then multiply by gain, in that order.
// - Round to 16 bits, clamp out-of-range results to full scale, twos or offset binary.
// - Coefficients load factory values at power-on.
// - Coefficient writes take effect only while the converter is idle.
// - Calibration code in mode field starts a cycle that overwrites the coefficient, except a gain cycle whose measured span is zero.
// - Self-offset uses internal zero input; self-gain uses internal full-scale input.
// - Offset calibration lasts three output periods chop off, two chop on, then idle.
// - Gain calibration has two stages, twice the offset calibration length.
// - Calibration start aborts conversion, uses filter rate, always returns to idle.
// - Offset coefficient is 16-bit twos complement spanning plus or minus one.
// - Positive offset reduces output; zero means no offset removal.
// - Offset-corrected value is scaled by gain coefficient over 16384.
// - Nominal gain 0x5555 gives about 1.3333, three-quarter span to full scale.
// - Normal mode K is 1, 2 for gains 2 and 128, 4 for 256, 8 for 512.
// - Low power mode forces gain 128 and K of 32.
// - Low power plus mode forces gain 512 and K of 8.
// - In low power modes K doubles with half regulator voltage as reference.
// - Filter config bit 15 enables chopping and shortens offset calibration.
// - Mode register bit 5 selects precision or low power reference.
`ifndef ADC_CAL_DEFINES_VH
`define ADC_CAL_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADR_MODE 12'h000
`define ADR_FILTER 12'h004
`define ADR_OFFSET 12'h008
`define ADR_GAIN 12'h00C
`define ADR_RESULT 12'h010
`define ADR_STATUS 12'h014
`define ADR_PGA 12'h018

// ----------------------------------------
// Fields
// ----------------------------------------
`define MODE_FIELD 2:0
`define MODE_PWR 4:3
`define MODE_REF_BIT 5
`define MODE_HALFREF_BIT 6
`define MODE_UNIPOLAR_BIT 7
`define FLT_CHOP_BIT 15
`define PGA_FIELD 3:0

// ----------------------------------------
// Mode codes
// ----------------------------------------
`define MD_IDLE 3'h0
`define MD_CONT 3'h1
`define MD_SELF_OFS 3'h4
`define MD_SELF_GAIN 3'h5
`define MD_SYS_OFS 3'h6
`define MD_SYS_GAIN 3'h7
`define PWR_NORMAL 2'h0
`define PWR_LOW 2'h1
`define PWR_LOWPLUS 2'h2

// ----------------------------------------
// Values
// ----------------------------------------
`define OFS_NOMINAL 16'h0000
`define GAIN_NOMINAL 16'h5555
`define FILTER_RESET 16'h0007
`define GAIN_SHIFT 14
`define PGA_GAIN2 4'h1
`define PGA_GAIN128 4'h7
`define PGA_GAIN256 4'h8
`define PGA_GAIN512 4'h9
`define PERIODS_CHOP 2'h2
`define PERIODS_NOCHOP 2'h3
`define FULL_POS 16'h7FFF
`define FULL_NEG 16'h8000

`endif

// ===== rtl/adc_cal.v
/*
  Post-filter correction datapath and calibration sequencer for one
  sigma-delta channel, with an APB register slave.
  Assumes the decimation filter delivers one sample per output period with
  a one-cycle valid strobe on clk, and that the analog front end honours
  the zero/full-scale input selects.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defines.vh"

module adc_cal #(
  parameter [15:0] FACTORY_OFFSET = 16'h0000,
  parameter [15:0] FACTORY_GAIN = 16'h5555,
  parameter IS_CURRENT = 1
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire filt_valid,
  input wire [23:0] filt_data,
  output wire conv_abort,
  output wire cal_zero_sel,
  output wire cal_full_sel,
  output wire ref_low_power,
  output wire [3:0] pga_eff,
  output reg [15:0] result_q,
  output reg result_valid_q
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CONV = 4'b0010;
  localparam [3:0] ST_CAL1 = 4'b0100;
  localparam [3:0] ST_CAL2 = 4'b1000;

  reg [3:0] state_q;
  reg [7:0] mode_q;
  reg [15:0] filter_q;
  reg [15:0] offset_q;
  reg [15:0] gain_q;
  reg [3:0] pga_q;
  reg [1:0] period_cnt_q;
  reg chop_have_q;
  reg signed [23:0] chop_first_q;
  reg [15:0] cal_ofs_q;

  wire wr_en = psel & penable & pwrite;
  wire idle = state_q == ST_IDLE;
  wire chop = filter_q[`FLT_CHOP_BIT];
  wire [2:0] md = mode_q[`MODE_FIELD];
  wire is_cal_code = md[2];
  wire is_gain_cal = md == `MD_SELF_GAIN || md == `MD_SYS_GAIN;
  wire is_self = md == `MD_SELF_OFS || md == `MD_SELF_GAIN;
  wire [1:0] pwr = mode_q[`MODE_PWR];
  wire [1:0] periods = chop ? `PERIODS_CHOP : `PERIODS_NOCHOP;
  wire cal_run = (state_q == ST_CAL1) | (state_q == ST_CAL2);
  wire start_cal = wr_en && paddr == `ADR_MODE && pwdata[2];

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign conv_abort = start_cal & ~idle;
  assign ref_low_power = mode_q[`MODE_REF_BIT];
  // Self-offset and the first self-gain stage see internal zero; self-gain stage two full scale
  assign cal_zero_sel = cal_run & is_self & (state_q == ST_CAL1);
  assign cal_full_sel = cal_run & is_self & (state_q == ST_CAL2) & is_gain_cal;

  // ----------------------------------------
  // Effective amplifier gain and K factor
  // ----------------------------------------
  assign pga_eff = pwr == `PWR_LOW ? `PGA_GAIN128 : pwr == `PWR_LOWPLUS ? `PGA_GAIN512 : pga_q;

  reg [5:0] k_shift;
  always @*
  begin
    k_shift = 6'd0;
    if (IS_CURRENT != 0)
    begin
      case (pwr)
        `PWR_LOW: k_shift = 6'd5;
        `PWR_LOWPLUS: k_shift = 6'd3;
        default:
        begin
          case (pga_q)
            `PGA_GAIN2, `PGA_GAIN128: k_shift = 6'd1;
            `PGA_GAIN256: k_shift = 6'd2;
            `PGA_GAIN512: k_shift = 6'd3;
            default: k_shift = 6'd0;
          endcase
        end
      endcase
      if (pwr != `PWR_NORMAL && mode_q[`MODE_HALFREF_BIT])
        k_shift = k_shift + 6'd1;
    end
  end

  // ----------------------------------------
  // Correction datapath
  // ----------------------------------------
  // Filter data is a fraction with 23 fraction bits; the offset coefficient
  // spans +-1 in 15 fraction bits, so it is shifted up by 8 before K.
  wire signed [24:0] avg = ($signed({chop_first_q[23], chop_first_q}) + $signed({filt_data[23], filt_data})) >>> 1;
  wire chop_done = chop_have_q;
  wire signed [23:0] sample = chop ? avg[23:0] : $signed(filt_data);
  wire signed [39:0] ofs_scaled = $signed({{24{offset_q[15]}}, offset_q}) <<< (k_shift + 6'd8);
  wire signed [39:0] diff = $signed({{16{sample[23]}}, sample}) - ofs_scaled;
  wire signed [56:0] prod = diff * $signed({1'b0, gain_q});
  // Back to 16 result bits: drop 14 gain bits and 8 fraction bits, round half up
  wire signed [56:0] rnd = (prod + (57'sd1 <<< (`GAIN_SHIFT + 7))) >>> (`GAIN_SHIFT + 8);
  wire over = rnd > 57'sd32767;
  wire under = rnd < -57'sd32768;
  wire [15:0] clamped = over ? `FULL_POS : under ? `FULL_NEG : rnd[15:0];
  wire [15:0] formatted = mode_q[`MODE_UNIPOLAR_BIT] ? {~clamped[15], clamped[14:0]} : clamped;
  // Gain stage two measures the span above the zero reading of stage one
  wire signed [39:0] zero_scaled = $signed({{24{cal_ofs_q[15]}}, cal_ofs_q}) <<< (k_shift + 6'd8);
  wire signed [39:0] span = $signed({{16{sample[23]}}, sample}) - zero_scaled;
  wire signed [31:0] span_div = $signed({{8{span[31]}}, span[31:8]});
  // Zero span would divide by zero; the old coefficient is kept then
  wire span_zero = span_div == 32'sh0000_0000;
  wire signed [31:0] gain_quot = span_zero ? 32'sh0000_0000 : 32'sh2000_0000 / span_div;
  // Chopped data forms a result on every second filter sample
  wire sample_ok = filt_valid & (~chop | chop_done);

  // ----------------------------------------
  // Registers and sequencer
  // ----------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      mode_q <= 8'h00;
      filter_q <= `FILTER_RESET;
      offset_q <= FACTORY_OFFSET;
      gain_q <= FACTORY_GAIN;
      pga_q <= 4'h0;
      period_cnt_q <= 2'h0;
      chop_have_q <= 1'b0;
      chop_first_q <= 24'h00_0000;
      cal_ofs_q <= 16'h0000;
      result_q <= 16'h0000;
      result_valid_q <= 1'b0;
    end
    else
    begin
      result_valid_q <= 1'b0;
      if (filt_valid)
      begin
        chop_have_q <= chop & ~chop_have_q;
        chop_first_q <= $signed(filt_data);
      end
      if (wr_en)
      begin
        case (paddr)
          `ADR_MODE: mode_q <= pwdata[7:0];
          `ADR_FILTER: filter_q <= pwdata[15:0];
          `ADR_PGA: pga_q <= pwdata[3:0];
          `ADR_OFFSET: if (idle) offset_q <= pwdata[15:0];
          `ADR_GAIN: if (idle) gain_q <= pwdata[15:0];
          default: ;
        endcase
      end
      case (state_q)
        ST_IDLE, ST_CONV:
        begin
          if (start_cal)
          begin
            state_q <= ST_CAL1;
            period_cnt_q <= 2'h0;
            chop_have_q <= 1'b0;
          end
          else if (wr_en && paddr == `ADR_MODE)
            state_q <= pwdata[2:0] == `MD_CONT ? ST_CONV : ST_IDLE;
          else if (state_q == ST_CONV && sample_ok)
          begin
            result_q <= formatted;
            result_valid_q <= 1'b1;
          end
        end
        ST_CAL1, ST_CAL2:
        begin
          if (filt_valid)
          begin
            period_cnt_q <= period_cnt_q + 2'h1;
            // Last period of the stage holds the settled sample
            if (period_cnt_q == periods - 2'h1)
            begin
              period_cnt_q <= 2'h0;
              chop_have_q <= 1'b0;
              if (state_q == ST_CAL1)
              begin
                // Offset is the raw sample in offset units at K
                cal_ofs_q <= $signed(sample[23:8]) >>> k_shift[3:0];
                if (is_gain_cal)
                  state_q <= ST_CAL2;
                else
                begin
                  offset_q <= $signed(sample[23:8]) >>> k_shift[3:0];
                  state_q <= ST_IDLE;
                  mode_q[`MODE_FIELD] <= `MD_IDLE;
                end
              end
              else
              begin
                // Gain = full scale over measured span, in 2.14 format
                gain_q <= span_zero ? gain_q : gain_quot[15:0];
                state_q <= ST_IDLE;
                mode_q[`MODE_FIELD] <= `MD_IDLE;
              end
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @*
  begin
    case (paddr)
      `ADR_MODE: prdata = {24'h00_0000, mode_q};
      `ADR_FILTER: prdata = {16'h0000, filter_q};
      `ADR_OFFSET: prdata = {16'h0000, offset_q};
      `ADR_GAIN: prdata = {16'h0000, gain_q};
      `ADR_RESULT: prdata = {16'h0000, result_q};
      `ADR_STATUS: prdata = {28'h000_0000, state_q};
      `ADR_PGA: prdata = {28'h000_0000, pga_q};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule
`default_nettype wire

// ===== verification/adc_cal_asserts.sv
/*
  Concurrent checks on the ports of the converter correction block.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_cal_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic filt_valid,
  input wire logic conv_abort,
  input wire logic cal_zero_sel,
  input wire logic cal_full_sel,
  input wire logic ref_low_power,
  input wire logic [3:0] pga_eff,
  input wire logic result_valid_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_mwr;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence
  sequence s_code(logic [2:0] c);
    s_mwr ##0 pwdata[2:0] == c;
  endsequence
  chk_ref_select: assert property (s_mwr |=> ref_low_power == $past(pwdata[5]))
    else $error("reference select does not follow mode write");
  chk_lp_gain: assert property (s_mwr ##0 pwdata[4:3] == 2'h1 |=> pga_eff == 4'h7)
    else $error("low power gain not forced");
  chk_lpp_gain: assert property (s_mwr ##0 pwdata[4:3] == 2'h2 |=> pga_eff == 4'h9)
    else $error("low power plus gain not forced");
  chk_abort_cause: assert property (conv_abort |-> s_mwr and pwdata[2])
    else $error("abort without calibration start");
  chk_sel_excl: assert property (!(cal_zero_sel && cal_full_sel))
    else $error("zero and full inputs selected together");
  chk_self_zero: assert property (s_code(3'h4) |=> cal_zero_sel && !cal_full_sel)
    else $error("self offset without zero input");
  chk_self_gain: assert property (s_code(3'h5) |=> cal_zero_sel || cal_full_sel)
    else $error("self gain without internal input");
  chk_sys_ext: assert property (s_code(3'h6) |=> !cal_zero_sel && !cal_full_sel)
    else $error("system offset uses internal input");
  chk_result_src: assert property ($rose(result_valid_q) |-> $past(filt_valid))
    else $error("result without filter sample");
endmodule
bind adc_cal adc_cal_asserts i_adc_cal_asserts (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .filt_valid(filt_valid), .conv_abort(conv_abort),
  .cal_zero_sel(cal_zero_sel), .cal_full_sel(cal_full_sel), .ref_low_power(ref_low_power),
  .pga_eff(pga_eff), .result_valid_q(result_valid_q));
`default_nettype wire

// ===== verification/adc_cal_test.sv
/*
  Self-checking bench for the correction block over APB and the filter strobe.
  Assumes a zero-wait slave and a registered one-cycle result strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_cal_defines.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module adc_cal_test;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, filt_valid = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic [23:0] filt_data = '0;
  logic pready, pslverr, conv_abort, cal_zero_sel, cal_full_sel, ref_low_power, result_valid_q;
  logic [3:0] pga_eff;
  logic [15:0] result_q, got;
  int miscompares = 0, cmp_count = 0, nres = 0;
  logic [23:0] gd [4] = '{24'h30_0000, 24'hD0_0000, 24'h7F_FFFF, 24'h80_0000};
  logic [15:0] ge [4] = '{16'h4000, 16'hC000, 16'h7FFF, 16'h8000};
  logic [7:0] km [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h49, 8'h11, 8'h51};
  logic [3:0] kp [10] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'h9, 4'h3, 4'h0, 4'h0, 4'h0, 4'h0};
  logic [15:0] ke [10] = '{16'h0F00, 16'h0E00, 16'h0E00, 16'h0C00, 16'h0800, 16'h0F00, 16'hF000,
    16'hD000, 16'h0800, 16'h0000};
  always #5 clk = ~clk;
  adc_cal i_adc_cal (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filt_valid(filt_valid), .filt_data(filt_data), .conv_abort(conv_abort),
    .cal_zero_sel(cal_zero_sel), .cal_full_sel(cal_full_sel), .ref_low_power(ref_low_power),
    .pga_eff(pga_eff), .result_q(result_q), .result_valid_q(result_valid_q));
  always @(posedge clk)
    if (result_valid_q === 1'b1)
    begin
      got <= result_q;
      nres <= nres + 1;
    end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic smp(input logic [23:0] d);
    filt_valid <= 1'b1;
    filt_data <= d;
    @(posedge clk);
    filt_valid <= 1'b0;
    filt_data <= ~d;
    repeat (3) @(posedge clk);
  endtask
  // Status is polled after every sample so an early or late finish shows
  task automatic cal(input logic [2:0] m, input int n, input logic [23:0] d0, input logic [23:0] d1);
    apb(1'b1, `ADR_MODE, {29'h0, m});
    for (int i = 1; i <= n; i++)
    begin
      smp(i <= n / 2 ? d0 : d1);
      apb(1'b0, `ADR_STATUS, '0);
      `CHK("cal_idle", i == n, rv == 32'h0000_0001)
    end
    apb(1'b0, `ADR_MODE, '0);
    `CHK("mode_field", 3'h0, rv[2:0])
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    int k;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `ADR_OFFSET, '0);
    `CHK("ofs_reset", 16'h0000, rv[15:0])
    apb(1'b0, `ADR_GAIN, '0);
    `CHK("gain_reset", 16'h5555, rv[15:0])
    apb(1'b0, `ADR_FILTER, '0);
    `CHK("filter_reset", 16'h0007, rv[15:0])
    apb(1'b1, `ADR_MODE, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      smp(gd[i]);
      `CHK("gain_out", ge[i], got)
    end
    apb(1'b1, `ADR_MODE, '0);
    apb(1'b1, `ADR_OFFSET, 32'h0000_0100);
    apb(1'b1, `ADR_GAIN, 32'h0000_4000);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b1, `ADR_PGA, {28'h0, kp[i]});
      apb(1'b1, `ADR_MODE, {24'h00_0000, km[i]});
      smp(24'h10_0000);
      `CHK("k_scaled", ke[i], got)
      apb(1'b1, `ADR_MODE, '0);
    end
    apb(1'b1, `ADR_MODE, 32'h0000_0001);
    apb(1'b1, `ADR_OFFSET, 32'h0000_1234);
    apb(1'b0, `ADR_OFFSET, '0);
    `CHK("ofs_locked", 16'h0100, rv[15:0])
    cal(3'h4, 3, 24'h00_2000, 24'h00_2000);
    apb(1'b0, `ADR_OFFSET, '0);
    `CHK("ofs_cal", 16'h0020, rv[15:0])
    cal(3'h7, 6, 24'h00_0000, 24'h60_0000);
    apb(1'b0, `ADR_GAIN, '0);
    `CHK("gain_cal", 16'h5555, rv[15:0])
    apb(1'b1, `ADR_FILTER, 32'h0000_8007);
    cal(3'h6, 2, 24'h00_4000, 24'h00_4000);
    apb(1'b0, `ADR_OFFSET, '0);
    `CHK("ofs_chop", 16'h0040, rv[15:0])
    cal(3'h5, 4, 24'h00_0000, 24'h60_0000);
    apb(1'b1, `ADR_OFFSET, '0);
    apb(1'b1, `ADR_GAIN, 32'h0000_4000);
    apb(1'b1, `ADR_MODE, 32'h0000_0001);
    k = nres;
    smp(24'h10_0000);
    smp(24'h20_0000);
    `CHK("chop_avg", 16'h1800, got)
    `CHK("chop_count", k + 1, nres)
    apb(1'b1, `ADR_MODE, 32'h0000_0020);
    @(posedge clk);
    `CHK("ref_sel", 1'b1, ref_low_power)
    conclude;
  end
  initial
  begin
    #200_000;
    miscompares++;
    conclude;
  end
endmodule
`default_nettype wire
